// >>> hw/mrsr_pkg.sv
package mrsr_pkg;

  // register map
  localparam logic [7:0] REG_STATUS = 8'h00;
  localparam logic [7:0] REG_X_HIGH = 8'h01;
  localparam logic [7:0] REG_X_LOW = 8'h02;
  localparam logic [7:0] REG_Y_HIGH = 8'h03;
  localparam logic [7:0] REG_Y_LOW = 8'h04;
  localparam logic [7:0] REG_Z_HIGH = 8'h05;
  localparam logic [7:0] REG_Z_LOW = 8'h06;
  localparam logic [7:0] REG_PART_ID = 8'h07;
  localparam logic [7:0] REG_OP_STATE = 8'h08;
  localparam logic [7:0] PTR_STEP = 8'h01;
  localparam logic [7:0] PTR_SKIP = 8'h02;
  localparam logic [7:0] READ_ZERO = 8'h00;

  // status register fields
  localparam int BIT_ANY_OVERRUN = 7;
  localparam int BIT_OVERRUN_BASE = 4;
  localparam int BIT_ANY_READY = 3;
  localparam int BIT_READY_BASE = 0;
  localparam int NUM_AXES = 3;
  localparam int AXIS_X = 0;
  localparam int AXIS_Y = 1;
  localparam int AXIS_Z = 2;

  // operating_state codes
  localparam logic [1:0] MODE_STANDBY = 2'h0;
  localparam logic [1:0] MODE_ACTIVE_RAW = 2'h1;
  localparam logic [1:0] MODE_ACTIVE_CORR = 2'h2;
  localparam logic [5:0] MODE_PAD = 6'h00;

  // sample range limits in counts
  localparam logic signed [17:0] RAW_LIMIT = 18'sd20000;
  localparam logic signed [17:0] CORR_LIMIT = 18'sd30000;

  // i2c byte framing
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [3:0] BIT_ONE = 4'h1;
  localparam logic [3:0] BIT_ZERO = 4'h0;

  typedef enum logic [8:0] {
    ST_IDLE      = 9'h001,
    ST_ADDR      = 9'h002,
    ST_ADDR_ACK  = 9'h004,
    ST_PTR       = 9'h008,
    ST_PTR_ACK   = 9'h010,
    ST_WDATA     = 9'h020,
    ST_WDATA_ACK = 9'h040,
    ST_READ      = 9'h080,
    ST_READ_ACK  = 9'h100
  } mrsr_state_t;

  // acquisition results from the measurement engine
  typedef struct packed {
    logic [NUM_AXES-1:0] done;
    logic signed [NUM_AXES-1:0][17:0] value;
  } mrsr_acq_t;

endpackage : mrsr_pkg

// >>> hw/mrsr_readout.sv
`timescale 1ns/1ps

// How it works
// - reset clears all overrun and ready flags to zero.
// - combined overrun sets when any axis sample is overwritten unread.
// - combined overrun clears once all active axes' high bytes are read.
// - z overrun sets on unread z overwrite, clears on z high read.
// - y overrun sets on unread y overwrite, clears on y high read.
// - x overrun sets on unread x overwrite, clears on x high read.
// - combined ready is high while any enabled axis has new data.
// - combined ready clears once all enabled high bytes are read or their axes are disabled in axis_enable.
// - z ready sets on z acquisition, clears on z high read.
// - y ready sets on y acquisition, clears on y high read.
// - x ready sets on x acquisition, clears on x high read.
// - samples are signed 16-bit, high byte then low byte.
// - with bypass on, samples are limited to plus or minus 20000.
// - with correction on, samples span plus or minus 30000.
// - status and six sample bytes sit at consecutive auto-increment addresses.
// - fast read makes auto-increment skip each low byte.
// - direct reads of low bytes return the copy taken at the last x high read.
// - bytes after x high refresh only when x high is read.
// - read-only identifier register holds a fixed byte.
// - operating state shows mode in two low bits, upper zero.
// - irq pin follows new data, drops when x high is read.
// - offsets subtracted by engine unless bypass is set.
// - fast read bursts from x high deliver the x, y and z high bytes in turn.
module mrsr_readout #(
  parameter logic [6:0] DEVICE_ADDR = 7'h2A, // bus address
  parameter logic [7:0] PART_ID = 8'h5A // arbitrary identifier value
) (
  input wire logic clock, // system clock
  input wire logic rst, // synchronous reset, active high
  input wire logic scl_in, // i2c clock pin level
  input wire logic sda_in, // i2c data pin level
  output logic sda_out, // i2c data drive value
  output logic sda_oe, // i2c data drive enable
  input wire mrsr_pkg::mrsr_acq_t acq, // acquisition strobes and values
  input wire logic raw_bypass, // offset subtraction bypassed
  input wire logic sample_active, // engine measuring
  input wire logic fast_read, // skip low bytes on auto-increment
  input wire logic [2:0] axis_enable, // enabled axes z,y,x
  output logic sample_irq_pin // new-data interrupt pin
);

  logic [1:0] scl_sync;
  logic [1:0] sda_sync;
  logic scl_q;
  logic sda_q;
  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;

  mrsr_pkg::mrsr_state_t state;
  logic [3:0] bit_cnt;
  logic [7:0] shift;
  logic [7:0] ptr;
  logic [7:0] tx_addr;
  logic rw_bit;
  logic master_ack;
  logic [7:0] rd_byte;
  logic load_now;
  logic byte_sent;

  logic signed [15:0] live [mrsr_pkg::NUM_AXES];
  logic signed [15:0] shadow [mrsr_pkg::NUM_AXES];
  logic [2:0] ready;
  logic [2:0] overrun;
  logic [2:0] hi_read;
  logic any_overrun;
  logic any_ready;
  logic [7:0] op_state;

  function automatic logic signed [15:0] clamp_sample(
    input logic signed [17:0] v,
    input logic signed [17:0] lim
  );
    logic signed [17:0] r;
    r = v;
    // saturate instead of wrapping if the engine overshoots the range
    if (v > lim) begin
      r = lim;
    end else if (v < -lim) begin
      r = -lim;
    end
    return r[15:0];
  endfunction : clamp_sample

  function automatic logic [7:0] high_addr(input int axis);
    logic [7:0] a;
    a = mrsr_pkg::REG_X_HIGH;
    if (axis == mrsr_pkg::AXIS_Y) begin
      a = mrsr_pkg::REG_Y_HIGH;
    end else if (axis == mrsr_pkg::AXIS_Z) begin
      a = mrsr_pkg::REG_Z_HIGH;
    end
    return a;
  endfunction : high_addr

  function automatic logic [7:0] next_ptr(
    input logic [7:0] p,
    input logic skip_low
  );
    logic [7:0] n;
    // the pointer simply wraps past the top of the byte range
    n = 8'(p + mrsr_pkg::PTR_STEP);
    if (skip_low && (p == mrsr_pkg::REG_X_HIGH ||
        p == mrsr_pkg::REG_Y_HIGH || p == mrsr_pkg::REG_Z_HIGH)) begin
      n = 8'(p + mrsr_pkg::PTR_SKIP);
    end
    return n;
  endfunction : next_ptr

  function automatic logic [7:0] mode_byte(
    input logic active,
    input logic bypass
  );
    logic [1:0] code;
    code = mrsr_pkg::MODE_STANDBY;
    if (active && bypass) begin
      code = mrsr_pkg::MODE_ACTIVE_RAW;
    end else if (active) begin
      code = mrsr_pkg::MODE_ACTIVE_CORR;
    end
    return {mrsr_pkg::MODE_PAD, code};
  endfunction : mode_byte

  // pin synchronisers, idle bus reads high
  always_ff @(posedge clock) begin
    if (rst) begin
      scl_sync <= 2'h3;
      sda_sync <= 2'h3;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_sync <= {scl_sync[0], scl_in};
      sda_sync <= {sda_sync[0], sda_in};
      scl_q <= scl_sync[1];
      sda_q <= sda_sync[1];
    end
  end

  assign scl_rise = scl_sync[1] & ~scl_q;
  assign scl_fall = ~scl_sync[1] & scl_q;
  // start and stop are data edges seen while the clock stays high
  assign bus_start = scl_sync[1] & scl_q & sda_q & ~sda_sync[1];
  assign bus_stop = scl_sync[1] & scl_q & ~sda_q & sda_sync[1];

  // byte handed to the host; flags clear on its ack clock
  assign byte_sent = (state == mrsr_pkg::ST_READ_ACK) && scl_rise;
  // next byte is fetched on the fall that ends the ack slot
  assign load_now = scl_fall && (
    ((state == mrsr_pkg::ST_ADDR_ACK) && rw_bit) ||
    ((state == mrsr_pkg::ST_READ_ACK) && master_ack));

  // decoded, not stored, so it follows axis_enable at once
  assign any_ready = |(ready & axis_enable);

  // read data multiplexer
  always_comb begin
    rd_byte = mrsr_pkg::READ_ZERO;
    case (ptr)
      mrsr_pkg::REG_STATUS: begin
        rd_byte = {any_overrun, overrun, any_ready, ready};
      end
      mrsr_pkg::REG_X_HIGH: begin
        rd_byte = live[mrsr_pkg::AXIS_X][15:8];
      end
      mrsr_pkg::REG_X_LOW: begin
        rd_byte = shadow[mrsr_pkg::AXIS_X][7:0];
      end
      mrsr_pkg::REG_Y_HIGH: begin
        rd_byte = shadow[mrsr_pkg::AXIS_Y][15:8];
      end
      mrsr_pkg::REG_Y_LOW: begin
        rd_byte = shadow[mrsr_pkg::AXIS_Y][7:0];
      end
      mrsr_pkg::REG_Z_HIGH: begin
        rd_byte = shadow[mrsr_pkg::AXIS_Z][15:8];
      end
      mrsr_pkg::REG_Z_LOW: begin
        rd_byte = shadow[mrsr_pkg::AXIS_Z][7:0];
      end
      mrsr_pkg::REG_PART_ID: begin
        rd_byte = PART_ID;
      end
      mrsr_pkg::REG_OP_STATE: begin
        rd_byte = op_state;
      end
      // unmapped addresses read as zero
      default: begin
        rd_byte = mrsr_pkg::READ_ZERO;
      end
    endcase
  end

  // i2c slave sequencer
  always_ff @(posedge clock) begin
    if (rst) begin
      state <= mrsr_pkg::ST_IDLE;
      bit_cnt <= mrsr_pkg::BIT_ZERO;
      shift <= mrsr_pkg::READ_ZERO;
      ptr <= mrsr_pkg::REG_STATUS;
      tx_addr <= mrsr_pkg::REG_STATUS;
      rw_bit <= 1'b0;
      master_ack <= 1'b0;
      sda_oe <= 1'b0;
      sda_out <= 1'b0;
    end else if (bus_start) begin
      state <= mrsr_pkg::ST_ADDR;
      bit_cnt <= mrsr_pkg::BIT_ZERO;
      sda_oe <= 1'b0;
    end else if (bus_stop) begin
      state <= mrsr_pkg::ST_IDLE;
      sda_oe <= 1'b0;
    end else begin
      case (state)
        mrsr_pkg::ST_IDLE: begin
          sda_oe <= 1'b0;
        end
        mrsr_pkg::ST_ADDR, mrsr_pkg::ST_PTR, mrsr_pkg::ST_WDATA: begin
          if (scl_rise) begin
            shift <= {shift[6:0], sda_sync[1]};
            bit_cnt <= 4'(bit_cnt + mrsr_pkg::BIT_ONE);
          end else if (scl_fall && bit_cnt == mrsr_pkg::BITS_PER_BYTE) begin
            bit_cnt <= mrsr_pkg::BIT_ZERO;
            sda_oe <= 1'b1;
            if (state == mrsr_pkg::ST_ADDR) begin
              if (shift[7:1] == DEVICE_ADDR) begin
                rw_bit <= shift[0];
                state <= mrsr_pkg::ST_ADDR_ACK;
              end else begin
                sda_oe <= 1'b0;
                state <= mrsr_pkg::ST_IDLE;
              end
            end else if (state == mrsr_pkg::ST_PTR) begin
              ptr <= shift;
              state <= mrsr_pkg::ST_PTR_ACK;
            end else begin
              // written data is acknowledged and dropped
              ptr <= next_ptr(ptr, fast_read);
              state <= mrsr_pkg::ST_WDATA_ACK;
            end
          end
        end
        mrsr_pkg::ST_ADDR_ACK, mrsr_pkg::ST_READ_ACK: begin
          // host ack sampled on the rising clock, pointer steps there
          if (state == mrsr_pkg::ST_READ_ACK && scl_rise) begin
            master_ack <= ~sda_sync[1];
            ptr <= next_ptr(ptr, fast_read);
          end else if (load_now) begin
            shift <= rd_byte;
            tx_addr <= ptr;
            sda_oe <= ~rd_byte[7];
            bit_cnt <= mrsr_pkg::BIT_ONE;
            state <= mrsr_pkg::ST_READ;
          end else if (scl_fall) begin
            sda_oe <= 1'b0;
            state <= (state == mrsr_pkg::ST_ADDR_ACK) ? mrsr_pkg::ST_PTR :
                     mrsr_pkg::ST_IDLE;
          end
        end
        mrsr_pkg::ST_PTR_ACK, mrsr_pkg::ST_WDATA_ACK: begin
          if (scl_fall) begin
            sda_oe <= 1'b0;
            state <= mrsr_pkg::ST_WDATA;
          end
        end
        mrsr_pkg::ST_READ: begin
          // bit 7 went out at load; each fall shifts out the next one
          if (scl_fall) begin
            if (bit_cnt == mrsr_pkg::BITS_PER_BYTE) begin
              sda_oe <= 1'b0;
              state <= mrsr_pkg::ST_READ_ACK;
            end else begin
              sda_oe <= ~shift[6];
              shift <= {shift[6:0], 1'b0};
              bit_cnt <= 4'(bit_cnt + mrsr_pkg::BIT_ONE);
            end
          end
        end
        default: begin
          state <= mrsr_pkg::ST_IDLE;
          sda_oe <= 1'b0;
        end
      endcase
    end
  end

  // per-axis sample capture and flags
  genvar gi;
  generate
    for (gi = 0; gi < mrsr_pkg::NUM_AXES; gi++) begin : g_axis
      assign hi_read[gi] = byte_sent && (tx_addr == high_addr(gi));

      always_ff @(posedge clock) begin
        if (rst) begin
          live[gi] <= '0;
        end else if (acq.done[gi]) begin
          // engine delivers offset-corrected values unless bypassed
          live[gi] <= clamp_sample(acq.value[gi],
            raw_bypass ? mrsr_pkg::RAW_LIMIT :
            mrsr_pkg::CORR_LIMIT);
        end
      end

      // every axis is copied as x high goes out, keeping a burst coherent
      always_ff @(posedge clock) begin
        if (rst) begin
          shadow[gi] <= '0;
        end else if (load_now && ptr == mrsr_pkg::REG_X_HIGH) begin
          shadow[gi] <= live[gi];
        end
      end

      // set wins over a clear in the same cycle
      always_ff @(posedge clock) begin
        if (rst) begin
          ready[gi] <= 1'b0;
        end else if (acq.done[gi]) begin
          ready[gi] <= 1'b1;
        end else if (hi_read[gi]) begin
          ready[gi] <= 1'b0;
        end
      end

      always_ff @(posedge clock) begin
        if (rst) begin
          overrun[gi] <= 1'b0;
        end else if (acq.done[gi] && ready[gi]) begin
          overrun[gi] <= 1'b1;
        end else if (hi_read[gi]) begin
          overrun[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  // combined overrun drops with the last enabled high byte read
  always_ff @(posedge clock) begin
    if (rst) begin
      any_overrun <= 1'b0;
    end else if (|(acq.done & ready)) begin
      any_overrun <= 1'b1;
    end else if (|hi_read && !(|(ready & ~hi_read & axis_enable))) begin
      any_overrun <= 1'b0;
    end
  end

  // pin follows new data; only the x high transfer drops it
  always_ff @(posedge clock) begin
    if (rst) begin
      sample_irq_pin <= 1'b0;
    end else if (|(acq.done & axis_enable)) begin
      sample_irq_pin <= 1'b1;
    end else if (hi_read[mrsr_pkg::AXIS_X]) begin
      sample_irq_pin <= 1'b0;
    end
  end

  // mode byte follows the engine one cycle later
  always_ff @(posedge clock) begin
    if (rst) begin
      op_state <= mode_byte(1'b0, 1'b0);
    end else begin
      op_state <= mode_byte(sample_active, raw_bypass);
    end
  end

endmodule : mrsr_readout

// >>> tb/mrsr_readout_props.sv
`timescale 1ns/1ps
module mrsr_readout_props (
  input wire logic clock, // system clock
  input wire logic rst, // sync reset
  input wire logic scl_in, // link clock level
  input wire logic sda_in, // data line level
  input wire logic sda_out, // data drive value
  input wire logic sda_oe, // data drive enable
  input wire mrsr_pkg::mrsr_acq_t acq, // acquisitions
  input wire logic raw_bypass, // offset bypass
  input wire logic sample_active, // engine active
  input wire logic fast_read, // skip low bytes
  input wire logic [2:0] axis_enable, // enabled axes
  input wire logic sample_irq_pin // new-data pin
);
  logic en_done;
  assign en_done = |(acq.done & axis_enable);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  property p_rst_irq;
    disable iff (1'b0) rst |=> !sample_irq_pin;
  endproperty
  a_rst_irq: assert property (p_rst_irq)
    else $error("irq high after reset");
  property p_rst_oe;
    disable iff (1'b0) rst |=> !sda_oe;
  endproperty
  a_rst_oe: assert property (p_rst_oe)
    else $error("data line driven after reset");
  property p_irq_set;
    en_done |=> sample_irq_pin;
  endproperty
  a_irq_set: assert property (p_irq_set)
    else $error("irq not raised by enabled acquisition");
  property p_irq_cause;
    $rose(sample_irq_pin) |-> $past(en_done);
  endproperty
  a_irq_cause: assert property (p_irq_cause)
    else $error("irq rose without enabled acquisition");
  property p_irq_drop;
    $fell(sample_irq_pin) |-> $past(scl_in) || $past(scl_in, 2)
      || $past(scl_in, 3) || $past(scl_in, 4);
  endproperty
  a_irq_drop: assert property (p_irq_drop)
    else $error("irq dropped without a byte transfer");
  property p_disabled;
    acq.done != 3'h0 && !en_done && !sample_irq_pin |=> !sample_irq_pin;
  endproperty
  a_disabled: assert property (p_disabled)
    else $error("disabled axis raised irq");
  property p_oe_edge;
    $changed(sda_oe) |-> !scl_in;
  endproperty
  a_oe_edge: assert property (p_oe_edge)
    else $error("data drive changed while clock high");
  property p_oe_len;
    $rose(sda_oe) |-> ##[1:90] !sda_oe;
  endproperty
  a_oe_len: assert property (p_oe_len)
    else $error("data line held too long");
  property p_od;
    sda_oe |-> !sda_out;
  endproperty
  a_od: assert property (p_od)
    else $error("data line driven high");
endmodule : mrsr_readout_props

bind mrsr_readout mrsr_readout_props chk_u (.clock, .rst, .scl_in,
  .sda_in, .sda_out, .sda_oe, .acq, .raw_bypass, .sample_active,
  .fast_read, .axis_enable, .sample_irq_pin);

// >>> tb/mrsr_host_model.sv
`timescale 1ns/1ps
module mrsr_host_model (
  input wire logic clock, // system clock
  input wire logic sda_wire, // resolved data line
  output logic scl, // link clock
  output logic sda_drive_low, // pulls data line low
  output logic rx_valid, // byte received
  output logic [7:0] rx_byte // received byte
);
  initial begin
    scl = 1'b1;
    sda_drive_low = 1'b0;
    rx_valid = 1'b0;
    rx_byte = 8'h00;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
  endtask : tick
  // one bit: 5 cycles low, 3 high, data changes while low
  task automatic bit_io(input logic b, output logic r);
    scl <= 1'b0;
    tick(1);
    sda_drive_low <= !b;
    tick(4);
    scl <= 1'b1;
    tick(2);
    r = sda_wire;
    tick(1);
  endtask : bit_io
  // start: data falls while clock high; stop: data rises while clock high
  task automatic edge_c(input logic stop);
    scl <= 1'b0;
    tick(1);
    sda_drive_low <= stop;
    tick(4);
    scl <= 1'b1;
    tick(3);
    sda_drive_low <= !stop;
    tick(4);
  endtask : edge_c
  task automatic wbyte(input logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, r);
  endtask : wbyte
  task automatic rbyte(input logic last);
    logic [7:0] d;
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, r);
      d[i] = r;
    end
    bit_io(last, r);
    rx_byte <= d;
    rx_valid <= 1'b1;
    tick(1);
    rx_valid <= 1'b0;
  endtask : rbyte
  task automatic rd(input logic [6:0] dev, input logic [7:0] p, input int n);
    edge_c(1'b0);
    wbyte({dev, 1'b0});
    wbyte(p);
    edge_c(1'b0);
    wbyte({dev, 1'b1});
    for (int k = 0; k < n; k++) rbyte(k == n - 1);
    edge_c(1'b1);
  endtask : rd
  task automatic wr(input logic [6:0] dev, input logic [7:0] p, d);
    edge_c(1'b0);
    wbyte({dev, 1'b0});
    wbyte(p);
    wbyte(d);
    edge_c(1'b1);
  endtask : wr
endmodule : mrsr_host_model

// >>> tb/testbench.sv
`timescale 1ns/1ps
module testbench;
  localparam logic [6:0] DEV = 7'h2A;
  localparam logic [7:0] PID = 8'h3C; // arbitrary identifier value
  logic clock, rst, sda_out, sda_oe, irq, scl, host_low, rx_valid, aovr;
  logic raw_bypass, sample_active, fast_read;
  logic [2:0] axis_enable, rdy, ovr;
  logic [7:0] rx_byte;
  logic [7:0] exp_q[$];
  logic [15:0] live[3], snap[3];
  mrsr_pkg::mrsr_acq_t acq;
  int bad_count, samples_checked, seed;
  wire logic sda = !(sda_oe | host_low);
  mrsr_readout #(.DEVICE_ADDR(DEV), .PART_ID(PID)) dut_u (.clock, .rst,
    .scl_in(scl), .sda_in(sda), .sda_out, .sda_oe, .acq, .raw_bypass,
    .sample_active, .fast_read, .axis_enable, .sample_irq_pin(irq));
  mrsr_host_model host_u (.clock, .sda_wire(sda), .scl,
    .sda_drive_low(host_low), .rx_valid, .rx_byte);
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  task automatic print_verdict;
    $display("checked %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : print_verdict
  always @(posedge clock) begin
    if (rx_valid === 1'b1) begin
      samples_checked++;
      if (exp_q.size() == 0 || rx_byte !== exp_q[0]) begin
        bad_count++;
        $display("Error at %0t: read %h", $time, rx_byte);
      end
      if (exp_q.size() != 0) void'(exp_q.pop_front());
    end
  end
  // expected byte at address a, updating the flag model
  function automatic void note(input logic [7:0] a);
    int i;
    i = (a - 1) >> 1;
    if (a == 8'h01) snap = live;
    case (a)
      8'h00: exp_q.push_back({aovr, ovr, |(rdy & axis_enable), rdy});
      8'h01, 8'h03, 8'h05: begin
        exp_q.push_back(a == 8'h01 ? live[0][15:8] : snap[i][15:8]);
        rdy[i] = 1'b0;
        ovr[i] = 1'b0;
        if (!(|(rdy & axis_enable))) aovr = 1'b0;
      end
      8'h02, 8'h04, 8'h06: exp_q.push_back(snap[i][7:0]);
      8'h07: exp_q.push_back(PID);
      8'h08: exp_q.push_back({6'h00, !sample_active ? mrsr_pkg::MODE_STANDBY
        : raw_bypass ? mrsr_pkg::MODE_ACTIVE_RAW : mrsr_pkg::MODE_ACTIVE_CORR});
      default: exp_q.push_back(8'h00);
    endcase
  endfunction : note
  task automatic burst(input logic [7:0] a, input int n);
    logic [7:0] p;
    p = a;
    for (int k = 0; k < n; k++) begin
      note(p);
      p += (fast_read && p[0] && p < 8'h07) ? 8'h02 : 8'h01;
    end
    host_u.rd(DEV, a, n);
  endtask : burst
  task automatic sample(input logic [2:0] m, input int v);
    logic [2:0][17:0] v3;
    int r, lim;
    @(posedge clock);
    // read the limit only once a setting changed by the caller has landed
    lim = raw_bypass ? 20000 : 30000;
    for (int i = 0; i < 3; i++) begin
      r = (v != 0) ? v : $random(seed) % 20000;
      v3[i] = 18'(r);
      r = r > lim ? lim : (r < -lim ? -lim : r);
      if (m[i]) begin
        ovr[i] |= rdy[i];
        aovr |= rdy[i];
        rdy[i] = 1'b1;
        live[i] = 16'(r);
      end
    end
    acq <= {m, v3};
    @(posedge clock);
    acq.done <= 3'h0;
  endtask : sample
  initial begin
    repeat (90000) @(posedge clock);
    bad_count++;
    $display("Error at %0t: timeout", $time);
    print_verdict();
  end
  initial begin
    {rst, raw_bypass, axis_enable, acq, sample_active, fast_read} = '1;
    {acq, sample_active, fast_read, rdy, ovr, aovr} = '0;
    {bad_count, samples_checked, seed} = {32'h0, 32'h0, 32'h8035};
    for (int i = 0; i < 3; i++) {live[i], snap[i]} = 32'h0;
    repeat (5) @(posedge clock);
    rst <= 1'b0;
    repeat (5) @(posedge clock);
    burst(8'h00, 9);
    sample_active <= 1'b1;
    sample(3'h7, 0);
    sample(3'h1, 0);
    burst(8'h00, 7);
    burst(8'h00, 1);
    for (int i = 0; i < 3; i++) begin
      sample(3'(1 << i), 0);
      sample(3'(1 << i), 0);
      burst(8'h00, 1);
      burst(8'(1 + 2 * i), 1);
      burst(8'h00, 1);
    end
    burst(8'h01, 6);
    fast_read <= 1'b1;
    sample(3'h7, 0);
    burst(8'h01, 3);
    burst(8'h04, 1);
    fast_read <= 1'b0;
    axis_enable <= 3'h3;
    sample(3'h4, 0);
    burst(8'h00, 1);
    burst(8'h05, 1);
    axis_enable <= 3'h7;
    sample(3'h7, 25000);
    burst(8'h01, 6);
    raw_bypass <= 1'b0;
    sample(3'h7, -31000);
    burst(8'h01, 8);
    host_u.wr(DEV, 8'h00, 8'hFF);
    host_u.wr(DEV, 8'h07, 8'h00);
    burst(8'h00, 9);
    exp_q.push_back(8'hFF);
    host_u.rd(DEV ^ 7'h01, 8'h00, 1);
    sample_active <= 1'b0;
    @(posedge clock);
    burst(8'h08, 1);
    for (int k = 0; k < 100 && exp_q.size() != 0; k++) @(posedge clock);
    if (exp_q.size() != 0) begin
      bad_count++;
      $display("Error at %0t: %0d reads missing", $time, exp_q.size());
    end
    print_verdict();
  end
endmodule : testbench
